// ==== dv/scs_master_model.sv ====
// serial master standing in for the external controller
// assumes: tasks called one at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module scs_master_model (
    output logic sck,
    output logic selectN,
    output logic mosi,
    input wire logic misoOut,
    input wire logic misoOe
);
    // 100 ns sck: the read word is fetched across domains, faster is unsafe
    localparam time HALF = 50ns;
    logic miso;
    // released line shows the inverse of misoOut
    assign miso = misoOe ? misoOut : ~misoOut;
    initial begin
        sck = 1'b0;
        selectN = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic s, input logic [8:0] a, input logic w, input logic [15:0] d, input int n,
        output logic [15:0] r);
        logic [25:0] f;
        f = {a, w, d};
        r = 16'h0000;
        selectN = ~s;
        mosi = f[25];
        // one full sck period between select and the first rise
        #HALF;
        for (int i = 1; i <= n; i++) begin
            #HALF sck = 1'b1;
            #HALF if (i >= 12) r = {r[14:0], miso};
            sck = 1'b0;
            mosi = f[25 - (i % 26)];
        end
        #(2 * HALF) r = {r[14:0], miso};
        selectN = 1'b1;
        mosi = ~mosi;
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== dv/scs_serial_port_properties.sv ====
// checker of the serial port, watching its pins from the sys_clk side
// assumes: sck at most 10 MHz, so a frame spans at least 130 sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
module scs_port_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic selectN,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic writeSeen
);
    // ----------------------------------------
    // frame length helpers
    // ----------------------------------------
    // lowCnt_q keeps the last frame length while deselected
    logic [8:0] lowCnt_q;
    logic [3:0] highCnt_q;
    logic selPrev_q;
    always_ff @(posedge sys_clk) begin
        selPrev_q <= selectN;
        if (reset) lowCnt_q <= 9'h000;
        else if (!selectN) lowCnt_q <= (selPrev_q ? 9'h000 : lowCnt_q) + 9'h001;
        if (reset || !selectN) highCnt_q <= 4'h0;
        else highCnt_q <= highCnt_q + {3'h0, highCnt_q != 4'hF};
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_float_deselect: assert property (selectN |-> !misoOe) else $error("miso driven while deselected");
    a_oe_late: assert property ($rose(misoOe) |-> lowCnt_q > 9'h028) else $error("miso driven too early");
    a_oe_window: assert property (misoOe |-> lowCnt_q < 9'h0A0) else $error("miso driven too long");
    a_oe_hold: assert property ($rose(misoOe) |=> misoOe [*4]) else $error("read data dropped early");
    a_write_full: assert property (writeSeen |-> lowCnt_q > 9'h078) else $error("write from short frame");
    a_write_prompt: assert property (writeSeen |-> !selectN || highCnt_q < 4'hC) else $error("write late");
    a_read_no_write: assert property (misoOe |-> !writeSeen) else $error("write during read");
    a_strobe_single: assert property ($rose(writeSeen) |=> !writeSeen [*8]) else $error("strobe too long");
    cover property ($rose(misoOe));
    cover property ($rose(writeSeen));
    cover property ($rose(selectN) && lowCnt_q < 9'h078);
endmodule
bind scs_serial_port scs_port_props i_props (.sys_clk(sys_clk), .reset(reset), .sck(sck), .selectN(selectN),
    .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe), .writeSeen(writeSeen));
`default_nettype wire

// ==== dv/sensor_config_spi_slave_tb.sv ====
// self-checking bench of the serial configuration port
// assumes: master model drives the link pins, bench owns clock and reset
`timescale 1ns/1ps
`default_nettype none
module sensor_config_spi_slave_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sck, selectN, mosi, misoOut, misoOe, writeSeen;
    logic [15:0] rd;
    int failures = 0;
    int tests_run = 0;
    int wrCount = 0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (writeSeen === 1'b1) wrCount++;
    scs_serial_port i_dut (.sys_clk(sys_clk), .reset(reset), .sck(sck), .selectN(selectN), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe), .writeSeen(writeSeen));
    scs_master_model i_mst (.sck(sck), .selectN(selectN), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // addresses differing only at their ends catch a reversed bit order
    task automatic t_write_read();
        i_mst.xfer(1'b1, 9'h100, 1'b1, 16'hA5C3, 26, rd);
        i_mst.xfer(1'b1, 9'h001, 1'b1, 16'h5A3C, 26, rd);
        i_mst.xfer(1'b1, 9'h100, 1'b0, 16'h0000, 26, rd);
        check("read 100", 16'hA5C3, rd);
        i_mst.xfer(1'b1, 9'h001, 1'b0, 16'h0000, 26, rd);
        check("read 001", 16'h5A3C, rd);
        check("write strobes", 16'h0002, wrCount[15:0]);
        $display("test write_read done");
    endtask
    task automatic t_abort();
        i_mst.xfer(1'b1, 9'h100, 1'b1, 16'hFFFF, 20, rd);
        i_mst.xfer(1'b1, 9'h100, 1'b0, 16'h0000, 26, rd);
        check("after abort", 16'hA5C3, rd);
        check("abort strobes", 16'h0002, wrCount[15:0]);
        $display("test abort done");
    endtask
    task automatic t_deselected();
        i_mst.xfer(1'b0, 9'h155, 1'b1, 16'h1234, 26, rd);
        i_mst.xfer(1'b1, 9'h155, 1'b0, 16'h0000, 26, rd);
        check("unselected write", 16'h0000, rd);
        check("miso released", 16'h0000, {15'h0000, misoOe});
        $display("test deselected done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_write_read();
        t_abort();
        t_deselected();
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== hdl/scs_pkg.sv ====
// package of the sensor configuration serial port
// assumes: shared by the port core and its register bank
package scs_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 512;
    localparam int DIR_BIT_POS = 9;
    localparam int FRAME_BITS = 26;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_DIR = 5'h09;
    localparam logic [4:0] CNT_LAST = 5'h19;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ------------------------------------------------------------
    // system timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 50;
    localparam int SYNC_STAGES = 3;
endpackage

// ==== hdl/scs_regbank.sv ====
// register bank of the sensor configuration port, system clock domain
// assumes: one write strobe per committed frame, read address held stable
`timescale 1ns/1ps
`default_nettype none
module scs_regbank (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [8:0] wrAddr,
    input wire logic [15:0] wrData,
    input wire logic [8:0] rdAddr,
    output logic [15:0] rdData
);
    logic [15:0] regs_q [0:511];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < scs_pkg::REG_COUNT; gi++) begin : gReg
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    regs_q[gi] <= scs_pkg::REG_RESET;
                end else if (wrEn && wrAddr == 9'(gi)) begin
                    regs_q[gi] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdData <= scs_pkg::REG_RESET;
        end else begin
            rdData <= regs_q[rdAddr];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/scs_serial_port.sv ====
// serial configuration port: shift logic on sck, bank on sys_clk
// assumes: master keeps sck low outside frames and at most 10 MHz
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - nine address bits follow, msb first, captured in that order
// - mosi is sampled on rising sck edges, the data bits only in a write frame
// - tenth bit high means write, low means read
// - write sends sixteen data bits msb first into the addressed register
// - read shifts the addressed sixteen-bit word out msb first
// - miso floats whenever no read data is being returned
// - shift logic on sck; done and request flags synchronized into system clock, read word taken back on timing margin
module scs_serial_port (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic selectN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    output logic writeSeen
);
    // ------------------------------------------------------------
    // link side, clocked by sck
    // ------------------------------------------------------------
    logic [4:0] bitCnt_q;
    logic [8:0] addrSh_q;
    logic isWrite_q;
    logic [14:0] dataSh_q;
    logic [8:0] wrAddrL_q;
    logic [15:0] wrDataL_q;
    logic wrDone_q;
    logic rdReq_q;
    logic [15:0] rdShift_q;
    logic rdActive_q;
    logic [15:0] bankRdData;
    logic [15:0] rdHold_q;

    // select gating
    // selectN high holds the counter at zero so stray sck edges do nothing
    always_ff @(posedge sck or posedge selectN) begin
        if (selectN) begin
            bitCnt_q <= 5'h00;
        end else if (bitCnt_q != scs_pkg::CNT_LAST + 5'h01) begin
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    always_ff @(posedge sck) begin
        if (!selectN && bitCnt_q < scs_pkg::CNT_DIR) begin
            addrSh_q <= {addrSh_q[7:0], mosi};
        end
    end

    always_ff @(posedge sck) begin
        if (!selectN && bitCnt_q == scs_pkg::CNT_DIR) begin
            isWrite_q <= mosi;
        end
    end

    always_ff @(posedge sck) begin
        if (!selectN && isWrite_q && bitCnt_q > scs_pkg::CNT_DIR && bitCnt_q < scs_pkg::CNT_LAST) begin
            dataSh_q <= {dataSh_q[13:0], mosi};
        end
    end

    // commit on last bit
    // latched word stays stable while the done flag crosses; aborted frames never raise it
    always_ff @(posedge sck) begin
        if (!selectN && isWrite_q && bitCnt_q == scs_pkg::CNT_LAST) begin
            wrAddrL_q <= addrSh_q;
            wrDataL_q <= {dataSh_q, mosi};
        end
    end

    // level flags cleared by deselect: the link side has no other reset,
    // so a toggle would start unknown and never settle
    always_ff @(posedge sck or posedge selectN) begin
        if (selectN) begin
            wrDone_q <= 1'b0;
        end else if (isWrite_q && bitCnt_q == scs_pkg::CNT_LAST) begin
            wrDone_q <= 1'b1;
        end
    end

    // read request once the address is complete
    always_ff @(posedge sck or posedge selectN) begin
        if (selectN) begin
            rdReq_q <= 1'b0;
        end else if (bitCnt_q == scs_pkg::CNT_DIR - 5'h01) begin
            rdReq_q <= 1'b1;
        end
    end

    // read data shift
    // bank word sampled at the eleventh rise; sys domain has ~10 sys clocks by then
    // limitation: relies on sck no faster than 10 MHz against a 50 MHz bank clock
    always_ff @(negedge sck or posedge selectN) begin
        if (selectN) begin
            rdActive_q <= 1'b0;
            rdShift_q <= 16'h0000;
        end else if (bitCnt_q == scs_pkg::CNT_DIR + 5'h02 && !isWrite_q) begin
            rdActive_q <= 1'b1;
            rdShift_q <= rdHold_q;
        end else if (rdActive_q) begin
            // last bit stays driven until deselect so the master can take it
            rdShift_q <= {rdShift_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge sck) begin
        if (!selectN && bitCnt_q == scs_pkg::CNT_DIR + 5'h01) begin
            rdHold_q <= bankRdData;
        end
    end

    // output changes on falling edges for master sampling
    assign misoOe = rdActive_q & ~selectN;
    assign misoOut = rdShift_q[15];

    // ------------------------------------------------------------
    // system side, clocked by sys_clk
    // ------------------------------------------------------------
    logic [2:0] wrSync_q;
    logic wrSeen_q;
    logic bankWrEn;
    logic [8:0] bankWrAddr_q;
    logic [15:0] bankWrData_q;
    logic bankWrEn_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrSync_q <= 3'h0;
        end else begin
            wrSync_q <= {wrSync_q[1:0], wrDone_q};
        end
    end

    assign bankWrEn = wrSync_q[1] & ~wrSync_q[2];

    // word was stable since before the done flag left the link domain
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bankWrEn_q <= 1'b0;
            bankWrAddr_q <= 9'h000;
            bankWrData_q <= 16'h0000;
        end else begin
            bankWrEn_q <= bankWrEn;
            if (bankWrEn) begin
                bankWrAddr_q <= wrAddrL_q;
                bankWrData_q <= wrDataL_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrSeen_q <= 1'b0;
        end else begin
            wrSeen_q <= bankWrEn_q;
        end
    end

    assign writeSeen = wrSeen_q;

    // read address stable from the ninth bit until the frame ends
    logic [8:0] rdAddrHold_q;
    logic [2:0] rdSync_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdSync_q <= 3'h0;
            rdAddrHold_q <= 9'h000;
        end else begin
            rdSync_q <= {rdSync_q[1:0], rdReq_q};
            if (rdSync_q[1] & ~rdSync_q[2]) begin
                rdAddrHold_q <= addrSh_q;
            end
        end
    end

    scs_regbank uBank (
        .sys_clk(sys_clk),
        .reset(reset),
        .wrEn(bankWrEn_q),
        .wrAddr(bankWrAddr_q),
        .wrData(bankWrData_q),
        .rdAddr(rdAddrHold_q),
        .rdData(bankRdData)
    );
endmodule
`default_nettype wire
